// ---- core/ufc_pkg.sv ----
/*
  shared constants for the uart fifo control block: register map, control
  field positions, trigger tables, reset values, interrupt event layout.
  assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
*/
package ufc_pkg;
  // structure
  localparam int NUM_CH = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_FULL = 6'h20;
  localparam logic [5:0] CNT_ONE = 6'h01;

  // per-channel register offsets inside a 0x20 byte window
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_DATA = 5'h04;
  localparam logic [4:0] OFF_RXLVL = 5'h08;
  localparam logic [4:0] OFF_TXLVL = 5'h0C;
  localparam logic [4:0] OFF_FLO = 5'h10;
  localparam logic [4:0] OFF_FHI = 5'h14;
  localparam logic [4:0] OFF_STAT = 5'h18;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h40;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h44;

  // fifo_control field positions
  localparam int CTL_FEN = 0;
  localparam int CTL_RXCLR = 1;
  localparam int CTL_TXCLR = 2;
  localparam int CTL_DMA = 3;
  localparam int CTL_TXSEL = 4;
  localparam int CTL_RXSEL = 6;

  // trigger levels in bytes for the two-bit select fields
  localparam logic [7:0] RX_TRIG_00 = 8'h08;
  localparam logic [7:0] RX_TRIG_01 = 8'h10;
  localparam logic [7:0] RX_TRIG_10 = 8'h18;
  localparam logic [7:0] RX_TRIG_11 = 8'h1C;
  localparam logic [7:0] TX_TRIG_00 = 8'h10;
  localparam logic [7:0] TX_TRIG_01 = 8'h08;
  localparam logic [7:0] TX_TRIG_10 = 8'h18;
  localparam logic [7:0] TX_TRIG_11 = 8'h1E;
  localparam logic [7:0] NOFIFO_TRIG = 8'h01;

  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] LVL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;

  // interrupt status layout: four events per channel
  localparam int EV_RX_TRIG = 0;
  localparam int EV_TX_LOW = 1;
  localparam int EV_RX_TO = 2;
  localparam int EV_RX_OVR = 3;
  localparam int EV_PER_CH = 4;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : ufc_pkg

// ---- core/ufc_fifo.sv ----
/*
  byte fifo of 32 entries with synchronous clear; with the fifo switched
  off it holds a single byte. assumes fill and drain run on aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module ufc_fifo (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // control
  input wire logic clear,
  input wire logic fifo_on,
  // fill side
  input wire logic push,
  input wire logic [7:0] push_data,
  // drain side
  input wire logic pop,
  output logic [7:0] head,
  // status
  output logic [ufc_pkg::CNT_W-1:0] count,
  output logic full,
  output logic empty
);
  typedef struct packed {
    logic [ufc_pkg::FIFO_DEPTH-1:0][7:0] mem;
    logic [4:0] wp;
    logic [4:0] rp;
    logic [ufc_pkg::CNT_W-1:0] cnt;
  } ufc_fifo_st_t;

  ufc_fifo_st_t st_ff;
  ufc_fifo_st_t nxt_st;
  logic do_push;
  logic do_pop;

  // status taken straight from the registered state
  assign full = st_ff.cnt >= (fifo_on ? ufc_pkg::CNT_FULL : ufc_pkg::CNT_ONE);
  assign empty = st_ff.cnt == '0;
  assign count = st_ff.cnt;
  assign head = st_ff.mem[st_ff.rp];

  // next state; clear beats any push or pop in the same cycle
  always_comb begin
    nxt_st = st_ff;
    do_push = push && !full;
    do_pop = pop && !empty;
    if (clear) begin
      nxt_st.wp = '0;
      nxt_st.rp = '0;
      nxt_st.cnt = '0;
    end else begin
      if (do_push) begin
        nxt_st.mem[st_ff.wp] = push_data;
        nxt_st.wp = st_ff.wp + 5'h01;
      end
      if (do_pop) begin
        nxt_st.rp = st_ff.rp + 5'h01;
      end
      case ({do_push, do_pop})
        2'b10: nxt_st.cnt = st_ff.cnt + ufc_pkg::CNT_ONE;
        2'b01: nxt_st.cnt = st_ff.cnt - ufc_pkg::CNT_ONE;
        default: nxt_st.cnt = st_ff.cnt;
      endcase
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  property p_fill_past_trigger;
    (push && !full && !pop && !clear) |=> (count == $past(count) + 6'h01);
  endproperty
  a_fill_past_trigger: assert property (p_fill_past_trigger)
    else $error("fifo did not take a byte while not full");
endmodule : ufc_fifo
`default_nettype wire

// ---- core/ufc_top.sv ----
/*
  fifo control and dma ready pins for two uart channels behind an
  axi4-lite slave, with sticky event status, mask and one interrupt.
  assumes transmitter and receiver logic on aclk drive tx_take, rx_char.
*/
// How it works
// - receive fifo keeps taking bytes past the trigger until completely full
// - rx select bits 7:6 pick trigger 8, 16, 24 or 28 bytes
// - receive event raised when rx fill reaches the selected trigger
// - tx select bits 5:4 pick trigger 16, 8, 24 or 30 bytes
// - transmit event raised when tx fill drops below the trigger
// - any nonzero extended level register makes level registers the triggers
// - control bit 3 picks dma mode 0 (reset) or mode 1
// - mode 0 or no fifo: tx ready low while tx empty, high once loaded
// - mode 0 or no fifo: rx ready low while any byte held
// - mode 1: tx ready low below trigger, high when tx completely full
// - mode 1: rx ready low at trigger or timeout, high once empty
// - writing control bit 2 empties tx fifo, bit then clears itself
// - writing control bit 1 empties rx fifo, bit then clears itself
// - control bit 0 enables both fifos; clear means single-byte holding
// - mode 0: rx ready goes low when the holding stage gets a byte
`timescale 1ns/100ps
`default_nettype none
module ufc_top (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // transmitter side, per channel
  input wire logic [1:0] tx_take,
  output logic [1:0][7:0] tx_char,
  output logic [1:0] tx_char_valid,
  // receiver side, per channel
  input wire logic [1:0] rx_char_valid,
  input wire logic [1:0][7:0] rx_char,
  input wire logic [1:0] rx_timeout,
  // dma ready pins and interrupt
  output logic [1:0] transmit_ready_n,
  output logic [1:0] receive_ready_n,
  output logic irq
);
  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] fen;
    logic [1:0] dma1;
    logic [1:0] txclr;
    logic [1:0] rxclr;
    logic [1:0][1:0] rxsel;
    logic [1:0][1:0] txsel;
    logic [1:0][7:0] rxlvl;
    logic [1:0][7:0] txlvl;
    logic [1:0][7:0] flo;
    logic [1:0][7:0] fhi;
    logic [1:0] tx_pin_n;
    logic [1:0] rx_pin_n;
    logic [1:0] rx_hit_d;
    logic [1:0] tx_low_d;
    logic [7:0] irq_sts;
    logic [7:0] irq_mask;
  } ufc_state_t;

  ufc_state_t st_ff;
  ufc_state_t nxt_st;
  logic wr_fire;
  logic ar_fire;
  logic [1:0] tx_push;
  logic [1:0] rx_pop;
  logic [1:0] wr_ctl;
  logic [7:0] evt;
  logic [7:0] sts_clr;
  logic [1:0][5:0] tx_cnt;
  logic [1:0][5:0] rx_cnt;
  logic [1:0] tx_full;
  logic [1:0] rx_full;
  logic [1:0] tx_empty;
  logic [1:0] rx_empty;
  logic [1:0][7:0] rx_head;
  logic [1:0] ext;
  logic [1:0][7:0] rx_trig;
  logic [1:0][7:0] tx_trig;
  logic [1:0] rx_hit;
  logic [1:0] tx_low;

  // rx select field to byte count
  function automatic logic [7:0] rx_table(input logic [1:0] s);
    case (s)
      2'b00: rx_table = ufc_pkg::RX_TRIG_00;
      2'b01: rx_table = ufc_pkg::RX_TRIG_01;
      2'b10: rx_table = ufc_pkg::RX_TRIG_10;
      default: rx_table = ufc_pkg::RX_TRIG_11;
    endcase
  endfunction : rx_table

  // tx select field to byte count
  function automatic logic [7:0] tx_table(input logic [1:0] s);
    case (s)
      2'b00: tx_table = ufc_pkg::TX_TRIG_00;
      2'b01: tx_table = ufc_pkg::TX_TRIG_01;
      2'b10: tx_table = ufc_pkg::TX_TRIG_10;
      default: tx_table = ufc_pkg::TX_TRIG_11;
    endcase
  endfunction : tx_table

  // address decode shared by reads and writes
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == ufc_pkg::ADDR_IRQ_STS) || (a == ufc_pkg::ADDR_IRQ_MASK)
      || (a[7:6] == 2'b00 && a[1:0] == 2'b00 && a[4:0] <= ufc_pkg::OFF_STAT);
  endfunction : reg_hit

  // all assertions sample on aclk and rest in reset or while frozen
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  // per-channel fifos and trigger selection
  for (genvar c = 0; c < ufc_pkg::NUM_CH; c++) begin : g_ch
    ufc_fifo u_tx (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .clear(st_ff.txclr[c]),
      .fifo_on(st_ff.fen[c]),
      .push(tx_push[c]),
      .push_data(st_ff.w_data[7:0]),
      .pop(tx_take[c]),
      .head(tx_char[c]),
      .count(tx_cnt[c]),
      .full(tx_full[c]),
      .empty(tx_empty[c])
    );
    ufc_fifo u_rx (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .clear(st_ff.rxclr[c]),
      .fifo_on(st_ff.fen[c]),
      .push(rx_char_valid[c]),
      .push_data(rx_char[c]),
      .pop(rx_pop[c]),
      .head(rx_head[c]),
      .count(rx_cnt[c]),
      .full(rx_full[c]),
      .empty(rx_empty[c])
    );
    assign tx_char_valid[c] = !tx_empty[c];
    // extended levels override the select fields
    assign ext[c] = |{st_ff.rxlvl[c], st_ff.txlvl[c], st_ff.flo[c],
      st_ff.fhi[c]};
    assign rx_trig[c] = !st_ff.fen[c] ? ufc_pkg::NOFIFO_TRIG
      : ext[c] ? st_ff.rxlvl[c] : rx_table(st_ff.rxsel[c]);
    assign tx_trig[c] = !st_ff.fen[c] ? ufc_pkg::NOFIFO_TRIG
      : ext[c] ? st_ff.txlvl[c] : tx_table(st_ff.txsel[c]);
    assign rx_hit[c] = {2'b00, rx_cnt[c]} >= rx_trig[c];
    assign tx_low[c] = {2'b00, tx_cnt[c]} < tx_trig[c];

    property p_rx_sel_28;
      (st_ff.fen[c] && !ext[c] && st_ff.rxsel[c] == 2'b11)
        |-> rx_trig[c] == 8'h1C;
    endproperty
    a_rx_sel_28: assert property (p_rx_sel_28)
      else $error("rx trigger for select 11 is not 28");

    property p_tx_sel_30;
      (st_ff.fen[c] && !ext[c] && st_ff.txsel[c] == 2'b11)
        |-> tx_trig[c] == 8'h1E;
    endproperty
    a_tx_sel_30: assert property (p_tx_sel_30)
      else $error("tx trigger for select 11 is not 30");

    property p_ext_level;
      (st_ff.fen[c] && ext[c]) |-> rx_trig[c] == st_ff.rxlvl[c];
    endproperty
    a_ext_level: assert property (p_ext_level)
      else $error("extended rx level not used as trigger");

    property p_rx_event;
      (rx_hit[c] && !st_ff.rx_hit_d[c])
        |=> st_ff.irq_sts[c * ufc_pkg::EV_PER_CH + ufc_pkg::EV_RX_TRIG];
    endproperty
    a_rx_event: assert property (p_rx_event)
      else $error("rx trigger reached but no event bit");

    property p_tx_event;
      (tx_low[c] && !st_ff.tx_low_d[c])
        |=> st_ff.irq_sts[c * ufc_pkg::EV_PER_CH + ufc_pkg::EV_TX_LOW];
    endproperty
    a_tx_event: assert property (p_tx_event)
      else $error("tx below trigger but no event bit");

    property p_mode0_tx;
      (!st_ff.fen[c] || !st_ff.dma1[c]) |=>
        transmit_ready_n[c] == ($past(tx_cnt[c]) != 6'h00);
    endproperty
    a_mode0_tx: assert property (p_mode0_tx)
      else $error("mode 0 tx ready does not follow tx empty");

    property p_mode0_rx;
      (!st_ff.fen[c] || !st_ff.dma1[c]) && rx_cnt[c] != 6'h00
        |=> !receive_ready_n[c];
    endproperty
    a_mode0_rx: assert property (p_mode0_rx)
      else $error("mode 0 rx ready high while a byte is held");

    property p_mode1_tx_full;
      (st_ff.fen[c] && st_ff.dma1[c] && tx_full[c]) |=> transmit_ready_n[c];
    endproperty
    a_mode1_tx_full: assert property (p_mode1_tx_full)
      else $error("mode 1 tx ready low with tx full");

    property p_mode1_rx_hold;
      (st_ff.fen[c] && st_ff.dma1[c] && !receive_ready_n[c]
        && rx_cnt[c] != 6'h00 && $stable(st_ff.dma1[c]))
        |-> ##0 $past(!receive_ready_n[c]) || $past(rx_hit[c])
          || $past(rx_timeout[c]) || $past(!st_ff.dma1[c]);
    endproperty
    a_mode1_rx_hold: assert property (p_mode1_rx_hold)
      else $error("mode 1 rx ready fell without trigger or timeout");

    sequence s_tx_clr_pulse;
      st_ff.txclr[c] ##1 (!st_ff.txclr[c] && tx_cnt[c] == 6'h00);
    endsequence
    property p_tx_clear;
      (wr_ctl[c] && st_ff.w_data[ufc_pkg::CTL_TXCLR]) |=> s_tx_clr_pulse;
    endproperty
    a_tx_clear: assert property (p_tx_clear)
      else $error("tx clear did not empty fifo and self clear");

    sequence s_rx_clr_pulse;
      st_ff.rxclr[c] ##1 (!st_ff.rxclr[c] && rx_cnt[c] == 6'h00);
    endsequence
    property p_rx_clear;
      (wr_ctl[c] && st_ff.w_data[ufc_pkg::CTL_RXCLR]) |=> s_rx_clr_pulse;
    endproperty
    a_rx_clear: assert property (p_rx_clear)
      else $error("rx clear did not empty fifo and self clear");

    property p_single_hold;
      !st_ff.fen[c] && !$past(st_ff.fen[c])
        |-> tx_cnt[c] <= 6'h01 && rx_cnt[c] <= 6'h01;
    endproperty
    a_single_hold: assert property (p_single_hold)
      else $error("fifo holds more than one byte while disabled");
  end

  // bus handshakes; everything stalls while ce is low
  assign s_axi_awready = ce && !st_ff.aw_have && !st_ff.bvalid;
  assign s_axi_wready = ce && !st_ff.w_have && !st_ff.bvalid;
  assign s_axi_arready = ce && !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign transmit_ready_n = st_ff.tx_pin_n;
  assign receive_ready_n = st_ff.rx_pin_n;
  assign irq = |(st_ff.irq_sts & st_ff.irq_mask);

  // register file, bus slave, events and ready pins
  always_comb begin
    logic wch;
    logic rch;
    logic [7:0] d;
    nxt_st = st_ff;
    wch = st_ff.aw_addr[5];
    rch = s_axi_araddr[5];
    d = st_ff.w_data[7:0];
    wr_fire = st_ff.aw_have && st_ff.w_have && !st_ff.bvalid;
    ar_fire = s_axi_arvalid && s_axi_arready;
    tx_push = '0;
    rx_pop = '0;
    wr_ctl = '0;
    evt = '0;
    sts_clr = '0;
    nxt_st.txclr = '0;
    nxt_st.rxclr = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_have = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    // write side: both halves held, answer next cycle
    if (wr_fire) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = reg_hit(st_ff.aw_addr) ? ufc_pkg::RESP_OKAY
        : ufc_pkg::RESP_DECERR;
      if (reg_hit(st_ff.aw_addr) && st_ff.w_strb[0]) begin
        if (st_ff.aw_addr == ufc_pkg::ADDR_IRQ_MASK) begin
          nxt_st.irq_mask = d;
        end else if (!st_ff.aw_addr[6]) begin
          case (st_ff.aw_addr[4:0])
            ufc_pkg::OFF_CTRL: begin
              wr_ctl[wch] = 1'b1;
              nxt_st.fen[wch] = d[ufc_pkg::CTL_FEN];
              nxt_st.dma1[wch] = d[ufc_pkg::CTL_DMA];
              nxt_st.txsel[wch] = d[ufc_pkg::CTL_TXSEL +: 2];
              nxt_st.rxsel[wch] = d[ufc_pkg::CTL_RXSEL +: 2];
              // toggling the enable flushes both fifos
              nxt_st.txclr[wch] = d[ufc_pkg::CTL_TXCLR]
                || (d[ufc_pkg::CTL_FEN] != st_ff.fen[wch]);
              nxt_st.rxclr[wch] = d[ufc_pkg::CTL_RXCLR]
                || (d[ufc_pkg::CTL_FEN] != st_ff.fen[wch]);
            end
            ufc_pkg::OFF_DATA: tx_push[wch] = 1'b1;
            ufc_pkg::OFF_RXLVL: nxt_st.rxlvl[wch] = d;
            ufc_pkg::OFF_TXLVL: nxt_st.txlvl[wch] = d;
            ufc_pkg::OFF_FLO: nxt_st.flo[wch] = d;
            ufc_pkg::OFF_FHI: nxt_st.fhi[wch] = d;
            default: ;
          endcase
        end
      end
    end
    // read side: data reads pop, status reads clear
    if (ar_fire) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = '0;
      nxt_st.rresp = reg_hit(s_axi_araddr) ? ufc_pkg::RESP_OKAY
        : ufc_pkg::RESP_DECERR;
      if (s_axi_araddr == ufc_pkg::ADDR_IRQ_STS) begin
        nxt_st.rdata[7:0] = st_ff.irq_sts;
        sts_clr = st_ff.irq_sts;
      end else if (s_axi_araddr == ufc_pkg::ADDR_IRQ_MASK) begin
        nxt_st.rdata[7:0] = st_ff.irq_mask;
      end else if (reg_hit(s_axi_araddr)) begin
        case (s_axi_araddr[4:0])
          ufc_pkg::OFF_CTRL: nxt_st.rdata[7:0] = {st_ff.rxsel[rch],
            st_ff.txsel[rch], st_ff.dma1[rch], st_ff.txclr[rch],
            st_ff.rxclr[rch], st_ff.fen[rch]};
          ufc_pkg::OFF_DATA: begin
            nxt_st.rdata[7:0] = rx_empty[rch] ? 8'h00 : rx_head[rch];
            rx_pop[rch] = !rx_empty[rch];
          end
          ufc_pkg::OFF_RXLVL: nxt_st.rdata[7:0] = st_ff.rxlvl[rch];
          ufc_pkg::OFF_TXLVL: nxt_st.rdata[7:0] = st_ff.txlvl[rch];
          ufc_pkg::OFF_FLO: nxt_st.rdata[7:0] = st_ff.flo[rch];
          ufc_pkg::OFF_FHI: nxt_st.rdata[7:0] = st_ff.fhi[rch];
          ufc_pkg::OFF_STAT: begin
            nxt_st.rdata[5:0] = rx_cnt[rch];
            nxt_st.rdata[13:8] = tx_cnt[rch];
            nxt_st.rdata[16] = st_ff.rx_pin_n[rch];
            nxt_st.rdata[17] = st_ff.tx_pin_n[rch];
            nxt_st.rdata[18] = ext[rch];
          end
          default: ;
        endcase
      end
    end
    // per-channel events and dma ready pins
    for (int c = 0; c < ufc_pkg::NUM_CH; c++) begin
      evt[c * 4 + ufc_pkg::EV_RX_TRIG] = rx_hit[c] && !st_ff.rx_hit_d[c];
      evt[c * 4 + ufc_pkg::EV_TX_LOW] = tx_low[c] && !st_ff.tx_low_d[c];
      evt[c * 4 + ufc_pkg::EV_RX_TO] = rx_timeout[c];
      evt[c * 4 + ufc_pkg::EV_RX_OVR] = rx_char_valid[c] && rx_full[c];
      nxt_st.rx_hit_d[c] = rx_hit[c];
      nxt_st.tx_low_d[c] = tx_low[c];
      if (!st_ff.fen[c] || !st_ff.dma1[c]) begin
        nxt_st.tx_pin_n[c] = tx_cnt[c] != 6'h00;
        nxt_st.rx_pin_n[c] = rx_cnt[c] == 6'h00;
      end else begin
        if (tx_full[c]) begin
          nxt_st.tx_pin_n[c] = 1'b1;
        end else if (tx_low[c]) begin
          nxt_st.tx_pin_n[c] = 1'b0;
        end
        if (rx_hit[c] || rx_timeout[c]) begin
          nxt_st.rx_pin_n[c] = 1'b0;
        end else if (rx_cnt[c] == 6'h00) begin
          nxt_st.rx_pin_n[c] = 1'b1;
        end
      end
    end
    // a new event wins over the read that clears it
    nxt_st.irq_sts = (st_ff.irq_sts & ~sts_clr) | evt;
  end

  // state register, frozen while ce is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.tx_pin_n <= 2'b00;
      st_ff.rx_pin_n <= 2'b11;
      st_ff.irq_mask <= ufc_pkg::MASK_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  property p_sticky_set_wins;
    (ar_fire && s_axi_araddr == ufc_pkg::ADDR_IRQ_STS && rx_timeout[0])
      |=> st_ff.irq_sts[ufc_pkg::EV_RX_TO];
  endproperty
  a_sticky_set_wins: assert property (p_sticky_set_wins)
    else $error("event lost in the cycle of a status read");
endmodule : ufc_top
`default_nettype wire

// ---- tb/ufc_line_model.sv ----
/*
  line-side model: pops tx bytes and feeds rx bytes on command.
  assumes the bench raises drain and feed just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module ufc_line_model (
  // clock
  input wire logic aclk,
  // commands from the bench
  input wire logic [1:0] drain,
  input wire logic [1:0] feed,
  // design side
  input wire logic [1:0] tx_char_valid,
  output logic [1:0] tx_take,
  output logic [1:0] rx_char_valid,
  output logic [1:0][7:0] rx_char
);
  logic [7:0] seq_ff = 8'h00;
  // pop only a byte on offer, only while commanded
  assign tx_take = drain & tx_char_valid;
  assign rx_char_valid = feed;
  // data steps with every fed byte so a stale byte never looks held
  always_ff @(posedge aclk) begin
    if (feed != 2'h0) begin
      seq_ff <= seq_ff + 8'h01;
    end
  end
  assign rx_char = {seq_ff, ~seq_ff};
endmodule : ufc_line_model
`default_nettype wire

// ---- tb/tb.sv ----
/*
  self-checking bench: axi4-lite host tasks driving channel 0.
  assumes the register map of the package; ce is driven by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, lv;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0] bresp, rresp, rsp, drain = 2'h0, feed = 2'h0, rxto = 2'h0;
  logic [1:0] take, cval, rxv, txr_n, rxr_n;
  logic [1:0][7:0] txc, rxc;
  logic [7:0] rx_lv [4] = '{ufc_pkg::RX_TRIG_00, ufc_pkg::RX_TRIG_01,
    ufc_pkg::RX_TRIG_10, ufc_pkg::RX_TRIG_11};
  logic [7:0] tx_lv [4] = '{ufc_pkg::TX_TRIG_00, ufc_pkg::TX_TRIG_01,
    ufc_pkg::TX_TRIG_10, ufc_pkg::TX_TRIG_11};
  int err_total = 0, comparisons = 0;
  // 25 MHz clock
  always #20 aclk = ~aclk;
  ufc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_take(take),
    .tx_char(txc), .tx_char_valid(cval), .rx_char_valid(rxv),
    .rx_char(rxc), .rx_timeout(rxto), .transmit_ready_n(txr_n),
    .receive_ready_n(rxr_n), .irq(irq));
  ufc_line_model line_u (.aclk(aclk), .drain(drain), .feed(feed),
    .tx_char_valid(cval), .tx_take(take), .rx_char_valid(rxv),
    .rx_char(rxc));
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : tick
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    fork
      begin do @(posedge aclk); while (!awready); awvalid <= 1'h0; end
      begin do @(posedge aclk); while (!wready); wvalid <= 1'h0; end
    join
    while (!bvalid) @(posedge aclk);
    rsp = bresp;
    bready <= 1'h0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rsp = rresp;
    rready <= 1'h0;
    #1;
  endtask : rd
  // line model drains tx (tx=1) or feeds rx for n cycles
  task automatic run(input bit tx, input int n);
    @(posedge aclk);
    if (tx) drain[0] <= 1'h1;
    else feed[0] <= 1'h1;
    repeat (n) @(posedge aclk);
    drain[0] <= 1'h0;
    feed[0] <= 1'h0;
    tick(2);
  endtask : run
  task automatic wrap_up();
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    tick(1);
    rd(8'h00);
    chk("ctrl", d, 32'h0000_0000);
    chk("tx pin", txr_n, 32'h0000_0000);
    chk("rx pin", rxr_n, 32'h0000_0003);
    run(0, 1);
    chk("rx held", rxr_n, 32'h0000_0002);
    rd(8'h04);
    chk("rx data", d, 32'h0000_00FF);
    tick(2);
    chk("rx gone", rxr_n, 32'h0000_0003);
    wr(8'h04, 32'h0000_0055);
    tick(2);
    chk("tx loaded", txr_n, 32'h0000_0001);
    chk("tx head", txc[0], 32'h0000_0055);
    run(1, 1);
    chk("tx empty", txr_n, 32'h0000_0000);
    $display("test mode0 done");
    wr(8'h44, 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      lv = rx_lv[i];
      wr(8'h00, {24'h0, 2'(i), 6'h09});
      run(0, lv - 1);
      chk("rx below", rxr_n, 32'h0000_0003);
      rd(8'h40);
      run(0, 1);
      chk("rx trig", rxr_n, 32'h0000_0002);
      chk("irq", irq, 32'h0000_0001);
      run(0, 40 - lv);
      rd(8'h18);
      chk("rx full", d[5:0], ufc_pkg::CNT_FULL);
      chk("rx stay", rxr_n, 32'h0000_0002);
      wr(8'h00, {24'h0, 2'(i), 6'h0B});
      rd(8'h00);
      chk("clr bit", d, {24'h0, 2'(i), 6'h09});
      chk("rx clr", rxr_n, 32'h0000_0003);
      rd(8'h40);
      tick(2);
      chk("irq off", irq, 32'h0000_0000);
    end
    run(0, 1);
    chk("rx under", rxr_n, 32'h0000_0003);
    @(posedge aclk);
    rxto[0] <= 1'h1;
    @(posedge aclk);
    rxto[0] <= 1'h0;
    tick(2);
    chk("rx timeout", rxr_n, 32'h0000_0002);
    rd(8'h04);
    tick(2);
    chk("rx drained", rxr_n, 32'h0000_0003);
    $display("test rx done");
    for (int j = 0; j < 4; j++) begin
      lv = tx_lv[j];
      wr(8'h00, {24'h0, 2'h0, 2'(j), 4'h9});
      for (int k = 0; k < 32; k++) wr(8'h04, 32'(k));
      tick(2);
      chk("tx full", txr_n, 32'h0000_0001);
      rd(8'h40);
      run(1, 32 - lv);
      chk("tx mid", txr_n, 32'h0000_0001);
      run(1, 1);
      chk("tx low", txr_n, 32'h0000_0000);
      rd(8'h40);
      chk("tx event", d[1], 32'h0000_0001);
      wr(8'h00, {24'h0, 2'h0, 2'(j), 4'hD});
      rd(8'h18);
      chk("tx clr", d[13:8], 32'h0000_0000);
    end
    $display("test tx done");
    wr(8'h08, 32'h0000_0003);
    chk("bresp", rsp, ufc_pkg::RESP_OKAY);
    run(0, 3);
    chk("ext lvl", rxr_n, 32'h0000_0002);
    rd(8'h18);
    chk("ext flag", d[18], 32'h0000_0001);
    // bytes offered while ce is low must not land
    @(posedge aclk);
    ce <= 1'h0;
    run(0, 3);
    @(posedge aclk);
    ce <= 1'h1;
    rd(8'h18);
    chk("ce hold", d[5:0], 32'h0000_0003);
    wr(8'h80, 32'h0000_0000);
    chk("wr decerr", rsp, ufc_pkg::RESP_DECERR);
    rd(8'h80);
    chk("decerr", rsp, ufc_pkg::RESP_DECERR);
    $display("test misc done");
    wrap_up();
  end
  // watchdog well above the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
